// ### test/bcwp_ctrl_model.sv
/*
  Controller side model: word memory taking the packer's word writes,
  answering the ready flag with an acknowledge after a set delay.
  Assumes the packer's clock; only the low 8 address bits are decoded.
*/
`timescale 1ns/1ps
module bcwp_ctrl_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // Word writes
  input  wire logic        word_we_in,
  input  wire logic [15:0] word_addr_in,
  input  wire logic [15:0] word_data_in,
  // Handshake
  input  wire logic        ready_in,
  input  wire logic        ack_en_in,
  input  wire logic [3:0]  ack_delay_in,
  output logic             ack_out,
  output int               wr_count_out
);
  logic [15:0] mem_q [0:255];
  logic [3:0]  wait_q;
  // Untouched words keep a marker so that stray writes show up
  initial begin
    for (int i = 0; i < 256; i++) mem_q[i] = 16'hbeef;
  end
  always @(posedge clk_in) begin
    if (word_we_in) begin
      mem_q[word_addr_in[7:0]] <= word_data_in;
    end
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_count_out <= 0;
    end else if (word_we_in) begin
      wr_count_out <= wr_count_out + 1;
    end
  end
  // Ack held until ready falls, then released
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_out <= 1'b0;
      wait_q  <= 4'h0;
    end else if (ack_out) begin
      wait_q <= 4'h0;
      if (!ready_in) ack_out <= 1'b0;
    end else if (ready_in && ack_en_in) begin
      if (wait_q >= ack_delay_in) ack_out <= 1'b1;
      else wait_q <= wait_q + 4'h1;
    end else begin
      wait_q <= 4'h0;
    end
  end
endmodule

// ### test/bcwp_tb.sv
/*
  Self-checking bench for the bar code word packer: register port tasks,
  scanner serial driver and one task per scenario.
  Assumes bcwp_top with a short bit time and the controller model.
*/
`timescale 1ns/1ps
module testbench
  import bcwp_pkg::*;
;
  localparam int BITC = 16;
  logic              clk_in = 1'b0;
  logic              rst_b_in = 1'b0;
  logic [7:0]        reg_addr_in = 8'h00;
  logic [31:0]       reg_wdata_in = 32'h0;
  logic              reg_wr_in = 1'b0;
  logic              reg_rd_in = 1'b0;
  logic [31:0]       reg_rdata_out;
  logic              scan_rx_in = 1'b1;
  logic              host_xfer_req_in = 1'b0;
  logic [FUNC_N-1:0] port_owner_out;
  logic              xfer_mode_out;
  logic              word_we_out;
  logic [15:0]       word_addr_out;
  logic [15:0]       word_data_out;
  logic              scan_ready_out;
  logic              scan_discard_in = 1'b0;
  logic              scan_ack_in;
  logic              irq_out;
  // Ack stays off until a scenario has seen ready, so a short ready pulse is never missed
  logic              ack_en = 1'b0;
  int                wr_count;
  int                bad_count = 0;
  int                checks_done = 0;
  logic [31:0]       rd;
  int                c0;

  always #5 clk_in = ~clk_in;

  bcwp_top #(.BIT_CYCLES(BITC)) dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .scan_rx_in(scan_rx_in),
    .host_xfer_req_in(host_xfer_req_in), .port_owner_out(port_owner_out),
    .xfer_mode_out(xfer_mode_out), .word_we_out(word_we_out),
    .word_addr_out(word_addr_out), .word_data_out(word_data_out),
    .scan_ready_out(scan_ready_out), .scan_discard_in(scan_discard_in),
    .scan_ack_in(scan_ack_in), .irq_out(irq_out));

  bcwp_ctrl_model ctrl (.clk_in(clk_in), .rst_b_in(rst_b_in), .word_we_in(word_we_out),
    .word_addr_in(word_addr_out), .word_data_in(word_data_out),
    .ready_in(scan_ready_out), .ack_en_in(ack_en), .ack_delay_in(4'h3),
    .ack_out(scan_ack_in), .wr_count_out(wr_count));

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask

  task automatic send_byte(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    f = {1'b1, ^b ^ bad, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_in);
      scan_rx_in <= f[i];
      repeat (BITC - 1) @(posedge clk_in);
    end
  endtask

  task automatic send_frame(input string s);
    for (int i = 0; i < s.len(); i++) send_byte(s[i], 1'b0);
    send_byte(CHAR_CR, 1'b0);
    repeat (BITC) @(posedge clk_in);
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 200 && scan_ready_out !== 1'b1; i++) @(posedge clk_in);
    #1;
    check("ready raised", 32'h1, {31'h0, scan_ready_out});
  endtask

  task automatic handshake();
    wait_ready();
    ack_en <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk_in);
      #1;
      if (scan_ack_in === 1'b1) break;
    end
    @(posedge clk_in);
    #1;
    check("ready after ack", 32'h0, {31'h0, scan_ready_out});
    ack_en <= 1'b0;
  endtask

  task automatic setup(input logic [15:0] head, input logic [5:0] wc);
    reg_wr(REG_HEAD, {16'h0, head});
    reg_wr(REG_WCOUNT, {26'h0, wc});
    reg_wr(REG_STATUS, 32'h1f);
    c0 = wr_count;
  endtask

  task automatic t_reset();
    reg_rd(REG_CFG, rd);
    check("cfg reset", 32'h0, rd);
    reg_rd(REG_HEAD, rd);
    check("head reset", 32'h0, rd);
    reg_rd(REG_WCOUNT, rd);
    check("wcount reset", 32'h2, rd);
    reg_rd(8'h1c, rd);
    check("unmapped", 32'h0, rd);
  endtask

  task automatic t_wcount();
    logic [31:0] tv [4] = '{32'h1, 32'h21, 32'h20, 32'h2};
    logic [31:0] ev [4] = '{32'h2, 32'h2, 32'h20, 32'h2};
    for (int i = 0; i < 4; i++) begin
      reg_wr(REG_WCOUNT, tv[i]);
      reg_rd(REG_WCOUNT, rd);
      check("wcount", ev[i], rd);
    end
  endtask

  task automatic t_priority();
    logic [4:0] e;
    for (int c = 0; c < 32; c++) begin
      e = c[4:0] & (~c[4:0] + 5'h1);
      reg_wr(REG_CFG, c);
      reg_rd(REG_OWNER, rd);
      check("owner reg", {27'h0, e}, rd);
      check("owner", {27'h0, e}, {27'h0, port_owner_out});
      check("xfer mode", {31'h0, e[4]}, {31'h0, xfer_mode_out});
    end
    setup(16'h00e0, 6'h2);
    reg_wr(REG_CFG, 32'h3);
    send_frame("A");
    check("no writes under link", c0, wr_count);
    reg_wr(REG_CFG, 32'h1e);
    #1;
    check("scanner owns", 32'h2, {27'h0, port_owner_out});
  endtask

  task automatic t_host();
    reg_wr(REG_STATUS, 32'h1f);
    reg_wr(REG_MASK, 32'h8);
    #1;
    check("irq idle", 32'h0, {31'h0, irq_out});
    @(posedge clk_in);
    host_xfer_req_in <= 1'b1;
    @(posedge clk_in);
    host_xfer_req_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check("xfer mode kept", 32'h0, {31'h0, xfer_mode_out});
    check("irq raised", 32'h1, {31'h0, irq_out});
    reg_rd(REG_STATUS, rd);
    check("host refused", 32'h8, rd & 32'h8);
    reg_wr(REG_MASK, 32'h0);
    #1;
    check("irq masked", 32'h0, {31'h0, irq_out});
    reg_wr(REG_MASK, 32'h8);
    reg_wr(REG_STATUS, 32'h8);
    #1;
    check("irq cleared", 32'h0, {31'h0, irq_out});
  endtask

  task automatic t_short();
    setup(16'h0040, 6'h4);
    send_frame("ABC");
    handshake();
    check("count", 32'h3, {16'h0, ctrl.mem_q[8'h40]});
    check("word1", 32'h4241, {16'h0, ctrl.mem_q[8'h41]});
    check("word2", 32'h2043, {16'h0, ctrl.mem_q[8'h42]});
    check("word3", 32'h2020, {16'h0, ctrl.mem_q[8'h43]});
    check("writes", c0 + 4, wr_count);
    reg_rd(REG_STATUS, rd);
    check("stored", 32'h1, rd & 32'h3);
  endtask

  task automatic t_long();
    setup(16'h0080, 6'h2);
    send_frame("1234567");
    handshake();
    check("full count", 32'h7, {16'h0, ctrl.mem_q[8'h80]});
    check("word1", 32'h3231, {16'h0, ctrl.mem_q[8'h81]});
    check("past block", 32'hbeef, {16'h0, ctrl.mem_q[8'h82]});
    check("writes", c0 + 2, wr_count);
    reg_rd(REG_STATUS, rd);
    check("truncated", 32'h3, rd & 32'h3);
    reg_rd(REG_RXLEN, rd);
    check("rx length", 32'h7, rd);
    // A parity error poisons the frame up to its terminator
    c0 = wr_count;
    send_byte(8'h50, 1'b1);
    send_frame("");
    check("parity drop", c0, wr_count);
    reg_rd(REG_STATUS, rd);
    check("parity flag", 32'h10, rd & 32'h10);
  endtask

  task automatic t_block();
    setup(16'h00c0, 6'h2);
    ack_en <= 1'b0;
    send_frame("XY");
    wait_ready();
    c0 = wr_count;
    send_frame("Z");
    check("no write ready", c0, wr_count);
    reg_rd(REG_STATUS, rd);
    check("dropped", 32'h4, rd & 32'h4);
    ack_en <= 1'b1;
    handshake();
    scan_discard_in <= 1'b1;
    send_frame("D");
    check("no write discard", c0, wr_count);
    scan_discard_in <= 1'b0;
    send_frame("Q");
    handshake();
    check("count", 32'h1, {16'h0, ctrl.mem_q[8'hc0]});
    check("word1", 32'h2051, {16'h0, ctrl.mem_q[8'hc1]});
  endtask

  // Frames take about 180 cycles a character; the whole run is near 5k cycles
  initial begin
    #500_000;
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_reset();
    t_wcount();
    t_priority();
    t_host();
    t_short();
    t_long();
    t_block();
    print_verdict();
  end
endmodule

// ### verilog/bcwp_pkg.sv
/*
  Constants for the bar code word packer: timing, character codes,
  register map, field positions and reset values.
  Assumes a 100 MHz system clock and a 32-bit plain register port.
*/
// Behaviour
// - Each completed scan is written into a word block starting at a programmable head word.
// - Every data word after the head holds two character positions, scanned characters or space fill.
// - The destination word count is accepted only from 2 to 32 inclusive.
// - The head word receives the number of characters received from the scanner.
// - Characters go to successive words in ascending address order, in scan order.
// - Characters beyond the block are dropped; nothing is written past the block.
// - Unused character positions of a short scan are filled with space 20h.
// - The head count is the full received length, including truncated characters.
// - While the scanner function is enabled the serial port serves only the scanner; the code gives the port to the link when both are enabled.
// - A host transfer attempt fails while the scanner owns the port; no mode switch.
// - Port owner by fixed priority: link, scanner, printer, pass-through, screen transfer.
// - An enabled function disables every serial function of lower priority.
// - Scanner enable comes only from downloaded configuration, no local setting.
// - Scanner link is 9600 bps, 8 data bits, even parity, one stop bit.
// - A scan frame has no header, ASCII characters, and ends with carriage return.
// - Ready flag rises after storing a scan; acknowledge clears it.
// - No scan is written while discard, acknowledge or ready is set; discard clears it.
package bcwp_pkg;
  // Timing
  localparam int CLK_HZ     = 100_000_000;
  localparam int BAUD_BPS   = 9600;
  localparam int BIT_CYC    = CLK_HZ / BAUD_BPS;
  localparam int DATA_BITS  = 8;
  // Block geometry
  localparam int WCOUNT_MIN = 2;
  localparam int WCOUNT_MAX = 32;
  localparam int MAX_CHARS  = 2 * (WCOUNT_MAX - 1);
  // Character codes
  localparam logic [7:0] CHAR_CR    = 8'h0d;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  // Register offsets
  localparam logic [7:0] REG_CFG    = 8'h00;
  localparam logic [7:0] REG_HEAD   = 8'h04;
  localparam logic [7:0] REG_WCOUNT = 8'h08;
  localparam logic [7:0] REG_OWNER  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MASK   = 8'h14;
  localparam logic [7:0] REG_RXLEN  = 8'h18;
  // Function enable bits, highest priority first
  localparam int FUNC_N     = 5;
  localparam int CFG_LINK   = 0;
  localparam int CFG_SCAN   = 1;
  localparam int CFG_PRINT  = 2;
  localparam int CFG_PASS   = 3;
  localparam int CFG_XFER   = 4;
  // Status and mask bits
  localparam int ST_W        = 5;
  localparam int ST_STORED   = 0;
  localparam int ST_TRUNC    = 1;
  localparam int ST_DROP     = 2;
  localparam int ST_HOSTFAIL = 3;
  localparam int ST_PARERR   = 4;
  // Reset values
  localparam logic [FUNC_N-1:0] CFG_RST    = 5'h00;
  localparam logic [15:0]       HEAD_RST   = 16'h0000;
  localparam logic [5:0]        WCOUNT_RST = 6'h02;
endpackage

// ### verilog/bcwp_top.sv
/*
  Bar code word packer: scanner serial receiver, frame assembly,
  word writer toward the controller, port owner arbiter and registers.
  Assumes one 100 MHz clock; the scanner line is asynchronous, all other
  inputs come from logic on the same clock.
*/
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
module bcwp_top
  import bcwp_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC
)(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  // Register port
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [31:0]       reg_rdata_out,
  // Scanner serial line
  input  wire logic              scan_rx_in,
  // Serial port arbitration
  input  wire logic              host_xfer_req_in,
  output logic      [FUNC_N-1:0] port_owner_out,
  output logic                   xfer_mode_out,
  // Controller word writes
  output logic                   word_we_out,
  output logic      [15:0]       word_addr_out,
  output logic      [15:0]       word_data_out,
  // Controller handshake
  output logic                   scan_ready_out,
  input  wire logic              scan_discard_in,
  input  wire logic              scan_ack_in,
  // Interrupt
  output logic                   irq_out
);

  localparam int          CW        = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] BIT_FULL = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] BIT_HALF = CW'(BIT_CYCLES / 2);

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} bcwp_rx_t;
  typedef enum logic [1:0] {W_IDLE, W_HEAD, W_DATA} bcwp_wr_t;

  logic [FUNC_N-1:0] cfg_q;
  logic [15:0]       head_q;
  logic [5:0]        wcount_q;
  logic [ST_W-1:0]   status_q;
  logic [ST_W-1:0]   mask_q;
  logic [ST_W-1:0]   events;
  logic [31:0]       rdata_q;
  logic              scan_own;
  logic              rx_s1_q;
  logic              rx_s2_q;
  bcwp_rx_t          rx_st_q;
  logic [CW-1:0]     bit_cnt_q;
  logic [2:0]        bit_idx_q;
  logic [7:0]        shreg_q;
  logic              par_q;
  logic              par_bad_q;
  logic              char_stb_q;
  logic              char_ok_q;
  logic [7:0]        char_q;
  logic [7:0]        buf_q [MAX_CHARS];
  logic [15:0]       len_q;
  logic              skip_q;
  logic              blocked;
  logic              frame_go;
  bcwp_wr_t          wr_st_q;
  logic [15:0]       wr_len_q;
  logic [15:0]       head_lat_q;
  logic [5:0]        wc_lat_q;
  logic [5:0]        w_idx_q;
  logic [5:0]        pos;
  logic              ready_q;
  logic              wr_done;

  // Arbiter: lowest set enable bit wins, all others are masked off
  assign port_owner_out = cfg_q & ~(cfg_q - 5'h01);
  assign scan_own       = port_owner_out[CFG_SCAN];
  assign xfer_mode_out  = port_owner_out[CFG_XFER];

  // Configuration arrives only over the download port; no local pin enables it
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_q    <= CFG_RST;
      head_q   <= HEAD_RST;
      wcount_q <= WCOUNT_RST;
      mask_q   <= '0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        REG_CFG:  cfg_q <= reg_wdata_in[FUNC_N-1:0];
        REG_HEAD: head_q <= reg_wdata_in[15:0];
        REG_WCOUNT: begin
          // Out-of-range counts are ignored so the block never grows past 32 words
          if (reg_wdata_in >= 32'(WCOUNT_MIN) && reg_wdata_in <= 32'(WCOUNT_MAX)) begin
            wcount_q <= reg_wdata_in[5:0];
          end
        end
        REG_MASK: mask_q <= reg_wdata_in[ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status: a new event beats a write-one clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status_q <= '0;
    end else if (reg_wr_in && reg_addr_in == REG_STATUS) begin
      status_q <= (status_q & ~reg_wdata_in[ST_W-1:0]) | events;
    end else begin
      status_q <= status_q | events;
    end
  end
  assign irq_out = |(status_q & mask_q);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= '0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        REG_CFG:    rdata_q <= {27'h0, cfg_q};
        REG_HEAD:   rdata_q <= {16'h0, head_q};
        REG_WCOUNT: rdata_q <= {26'h0, wcount_q};
        REG_OWNER:  rdata_q <= {27'h0, port_owner_out};
        REG_STATUS: rdata_q <= {27'h0, status_q};
        REG_MASK:   rdata_q <= {27'h0, mask_q};
        REG_RXLEN:  rdata_q <= {16'h0, wr_len_q};
        default:    rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata_out = rdata_q;

  // Two-stage synchroniser on the scanner line
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= scan_rx_in;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Fixed 8E1 receiver sampling at mid-bit; not configurable by design
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_st_q    <= RX_IDLE;
      bit_cnt_q  <= '0;
      bit_idx_q  <= '0;
      shreg_q    <= '0;
      par_q      <= 1'b0;
      par_bad_q  <= 1'b0;
      char_stb_q <= 1'b0;
      char_ok_q  <= 1'b0;
      char_q     <= '0;
    end else begin
      char_stb_q <= 1'b0;
      if (bit_cnt_q != '0) begin
        bit_cnt_q <= bit_cnt_q - 1'b1;
      end
      case (rx_st_q)
        RX_IDLE: begin
          if (scan_own && !rx_s2_q) begin
            rx_st_q   <= RX_START;
            bit_cnt_q <= BIT_HALF;
          end
        end
        RX_START: begin
          if (bit_cnt_q == '0) begin
            rx_st_q   <= rx_s2_q ? RX_IDLE : RX_DATA;
            bit_cnt_q <= BIT_FULL;
            bit_idx_q <= '0;
            par_q     <= 1'b0;
          end
        end
        RX_DATA: begin
          if (bit_cnt_q == '0) begin
            shreg_q   <= {rx_s2_q, shreg_q[7:1]};
            par_q     <= par_q ^ rx_s2_q;
            bit_idx_q <= bit_idx_q + 3'h1;
            bit_cnt_q <= BIT_FULL;
            if (bit_idx_q == 3'(DATA_BITS - 1)) begin
              rx_st_q <= RX_PAR;
            end
          end
        end
        RX_PAR: begin
          if (bit_cnt_q == '0) begin
            par_bad_q <= par_q ^ rx_s2_q;
            bit_cnt_q <= BIT_FULL;
            rx_st_q   <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (bit_cnt_q == '0) begin
            char_stb_q <= 1'b1;
            char_ok_q  <= rx_s2_q && !par_bad_q;
            char_q     <= shreg_q;
            rx_st_q    <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // The buffer is frozen while a scan is pending, so new characters cannot land
  assign blocked  = ready_q || scan_ack_in || scan_discard_in || wr_st_q != W_IDLE;
  assign frame_go = char_stb_q && char_ok_q && char_q == CHAR_CR && !skip_q && !blocked;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      len_q  <= '0;
      skip_q <= 1'b0;
    end else if (char_stb_q) begin
      if (blocked || !char_ok_q) begin
        len_q  <= '0;
        skip_q <= char_q != CHAR_CR;
      end else if (char_q == CHAR_CR) begin
        len_q  <= '0;
        skip_q <= 1'b0;
      end else if (!skip_q && len_q != 16'hffff) begin
        len_q <= len_q + 16'h1;
      end
    end else if (scan_discard_in) begin
      len_q <= '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (char_stb_q && char_ok_q && !blocked && !skip_q && char_q != CHAR_CR
        && len_q < 16'(MAX_CHARS)) begin
      buf_q[len_q[5:0]] <= char_q;
    end
  end

  function automatic logic [7:0] char_at(input logic [5:0] p);
    if ({10'h0, p} < wr_len_q) begin
      char_at = buf_q[p];
    end else begin
      char_at = CHAR_SPACE;
    end
  endfunction

  assign pos = 6'((w_idx_q - 6'h1) << 1);

  // Word writer: head first, then data words in ascending order
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_st_q       <= W_IDLE;
      wr_len_q      <= '0;
      head_lat_q    <= '0;
      wc_lat_q      <= WCOUNT_RST;
      w_idx_q       <= '0;
      word_we_out   <= 1'b0;
      word_addr_out <= '0;
      word_data_out <= '0;
    end else begin
      word_we_out <= 1'b0;
      case (wr_st_q)
        W_IDLE: begin
          if (frame_go) begin
            wr_len_q   <= len_q;
            head_lat_q <= head_q;
            wc_lat_q   <= wcount_q;
            wr_st_q    <= W_HEAD;
          end
        end
        W_HEAD: begin
          word_we_out   <= 1'b1;
          word_addr_out <= head_lat_q;
          word_data_out <= wr_len_q;
          w_idx_q       <= 6'h1;
          wr_st_q       <= W_DATA;
        end
        W_DATA: begin
          word_we_out   <= 1'b1;
          word_addr_out <= head_lat_q + {10'h0, w_idx_q};
          word_data_out <= {char_at(pos + 6'h1), char_at(pos)};
          w_idx_q       <= w_idx_q + 6'h1;
          if (w_idx_q == wc_lat_q - 6'h1) begin
            wr_st_q <= W_IDLE;
          end
        end
        default: wr_st_q <= W_IDLE;
      endcase
    end
  end

  assign wr_done = wr_st_q == W_DATA && w_idx_q == wc_lat_q - 6'h1;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ready_q <= 1'b0;
    end else if (wr_done) begin
      ready_q <= 1'b1;
    end else if (scan_ack_in) begin
      ready_q <= 1'b0;
    end
  end

  assign scan_ready_out = ready_q;

  always_comb begin
    events              = '0;
    events[ST_STORED]   = wr_done;
    events[ST_TRUNC]    = wr_done && wr_len_q > 16'(2 * (wc_lat_q - 6'h1));
    events[ST_DROP]     = char_stb_q && char_ok_q && blocked;
    events[ST_HOSTFAIL] = host_xfer_req_in && !xfer_mode_out;
    events[ST_PARERR]   = char_stb_q && !char_ok_q;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_head_write;
    word_we_out && word_addr_out == head_lat_q && word_data_out == wr_len_q;
  endsequence
  sequence s_first_data;
    word_we_out && word_addr_out == head_lat_q + 16'h1;
  endsequence
  property p_head_then_data;
    frame_go |=> ##1 s_head_write ##1 s_first_data;
  endproperty
  a_head_then_data: assert property (p_head_then_data) else $error("head word not written");
  property p_ascending;
    word_we_out && $past(word_we_out) |-> word_addr_out == $past(word_addr_out) + 16'h1;
  endproperty
  a_ascending: assert property (p_ascending) else $error("word addresses not ascending");
  // Ready and the last word leave on the same edge, so the live address is the last one
  property p_block_end;
    $rose(scan_ready_out) |-> word_addr_out == head_lat_q + {10'h0, wc_lat_q} - 16'h1;
  endproperty
  a_block_end: assert property (p_block_end) else $error("block end address wrong");
  property p_space_fill;
    wr_st_q == W_DATA && {10'h0, pos} >= wr_len_q |=> word_data_out[7:0] == CHAR_SPACE;
  endproperty
  a_space_fill: assert property (p_space_fill) else $error("unused position not space");
  property p_wcount_range;
    reg_wr_in && reg_addr_in == REG_WCOUNT
      && (reg_wdata_in > 32'(WCOUNT_MAX) || reg_wdata_in < 32'(WCOUNT_MIN))
      |=> wcount_q == $past(wcount_q);
  endproperty
  a_wcount_range: assert property (p_wcount_range) else $error("bad word count taken");
  property p_no_write_blocked;
    (scan_ready_out || scan_ack_in || scan_discard_in) && wr_st_q == W_IDLE |=> wr_st_q == W_IDLE;
  endproperty
  a_no_write_blocked: assert property (p_no_write_blocked) else $error("write while blocked");
  property p_ack_clears;
    scan_ack_in && scan_ready_out && !wr_done |=> !scan_ready_out;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ready not cleared");
  property p_scan_priority;
    cfg_q[CFG_SCAN] && !cfg_q[CFG_LINK] |-> port_owner_out == 5'h02 && !xfer_mode_out;
  endproperty
  a_scan_priority: assert property (p_scan_priority) else $error("scanner not owner");
  property p_host_fails;
    host_xfer_req_in && scan_own |=> status_q[ST_HOSTFAIL] && !xfer_mode_out;
  endproperty
  a_host_fails: assert property (p_host_fails) else $error("host transfer not refused");
  property p_rx_idle_unowned;
    !scan_own && rx_st_q == RX_IDLE |=> rx_st_q == RX_IDLE;
  endproperty
  a_rx_idle_unowned: assert property (p_rx_idle_unowned) else $error("rx ran unowned");
  property p_drop_blocked;
    char_stb_q && blocked |=> len_q == 16'h0;
  endproperty
  a_drop_blocked: assert property (p_drop_blocked) else $error("partial frame kept");
endmodule
